// ===== hdl/epi_ctrl.sv
// Purpose: External pin interrupt request latches, enables and status register
// Assumes: Pins asynchronous; bus and CPU strobes synchronous to mclk_i
// Notes: Factory options are module parameters
`timescale 1ns/1ns
module epi_ctrl import epi_pkg::*; #(
	parameter bit LOW_GROUP_OPT = 1'b0,
	parameter bit LEVEL_SENS_OPT = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire epi_bus_req_t bus_i,
	output logic [7:0] rdata_o,
	input wire epi_pins_t pins_i,
	input wire logic cpu_imask_i,
	input wire logic vec_fetch_i,
	input wire logic stop_wait_i,
	output logic irq_req_o,
	output logic [15:0] irq_vec_o,
	output logic branch_pin_level_o
);
	// ==========================================
	// Helper functions
	// Address decode shared by read and write paths
	function automatic logic csr_hit(
		input logic [7:0] addr
	);
		logic hit;
		hit = 1'h0;
		if (addr == EPI_CSR_ADDR) begin
			hit = 1'h1;
		end
		return hit;
	endfunction

	// Falling edge from two successive samples
	function automatic logic fell(
		input logic prev,
		input logic now
	);
		logic seen;
		seen = prev & ~now;
		return seen;
	endfunction

	// Rising edge on any bit of a group
	function automatic logic any_rose(
		input logic [3:0] prev,
		input logic [3:0] now
	);
		logic seen;
		seen = |(now & ~prev);
		return seen;
	endfunction

	// Status byte; ack and unused bits stay zero
	function automatic logic [7:0] status_byte(
		input logic me,
		input logic se,
		input logic mf,
		input logic sf
	);
		logic [7:0] b;
		b = EPI_ZERO_BYTE;
		b[EPI_MAIN_EN_BIT] = me;
		b[EPI_SEC_EN_BIT] = se;
		b[EPI_MAIN_FLAG_BIT] = mf;
		b[EPI_SEC_FLAG_BIT] = sf;
		return b;
	endfunction

	// ==========================================
	// State and internal signals
	epi_state_t s_q;
	epi_state_t s_d;
	logic irq_now;
	logic irq_prev;
	logic high_now;
	logic high_prev;
	logic [3:0] low_now;
	logic [3:0] low_prev;
	logic irq_fall;
	logic high_fall;
	logic low_rise;
	logic irq_level;
	logic low_level;
	logic level_act;
	logic main_set;
	logic sec_set;
	logic fetch_clr;
	logic main_flag;
	logic main_live;
	logic sec_live;
	logic csr_wr;
	logic csr_rd;
	logic main_ack;
	logic sec_ack;
	logic [7:0] status;

	// ==========================================
	// Synchronised pin views
	// edges from synchronised samples
	assign irq_now = s_q.irq_seen[0];
	assign irq_prev = s_q.irq_seen[1];
	assign high_now = s_q.high_sync[1];
	assign high_prev = s_q.high_seen;
	assign low_now = s_q.low_sync1;
	assign low_prev = s_q.low_seen;

	// ==========================================
	// Edge and level detection
	// dedicated pin falling edge
	assign irq_fall = fell(irq_prev, irq_now);
	assign high_fall = fell(high_prev, high_now);
	assign low_rise = LOW_GROUP_OPT & any_rose(low_prev, low_now);
	assign irq_level = ~irq_now;
	assign low_level = LOW_GROUP_OPT & (|low_now);
	assign level_act = irq_level | low_level;
	assign main_flag = s_q.main_latch | (LEVEL_SENS_OPT & level_act);

	// ==========================================
	// Set and clear qualifiers
	assign main_set = irq_fall | low_rise;
	assign sec_set = high_fall & s_q.sec_en;
	assign fetch_clr = vec_fetch_i & ~s_q.sec_en;
	assign csr_wr = bus_i.wr & csr_hit(bus_i.addr);
	assign csr_rd = bus_i.rd & csr_hit(bus_i.addr);
	assign main_ack = csr_wr & bus_i.wdata[EPI_MAIN_ACK_BIT];
	assign sec_ack = csr_wr & bus_i.wdata[EPI_SEC_ACK_BIT];
	assign status = status_byte(s_q.main_en, s_q.sec_en, main_flag, s_q.sec_latch);

	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		// Synchronisers: first stage feeds only second stage
		s_d.irq_sync[0] = pins_i.irq_pin_b;
		s_d.irq_sync[1] = s_q.irq_sync[0];
		s_d.irq_seen[0] = s_q.irq_sync[1];
		s_d.irq_seen[1] = s_q.irq_seen[0];
		s_d.low_sync0 = pins_i.low_port_pin_group;
		s_d.low_sync1 = s_q.low_sync0;
		s_d.low_seen = s_q.low_sync1;
		s_d.high_sync[0] = pins_i.high_port_pin;
		s_d.high_sync[1] = s_q.high_sync[0];
		s_d.high_seen = s_q.high_sync[1];
		if (fetch_clr) begin
			s_d.main_latch = 1'h0;
		end
		if (main_ack) begin
			s_d.main_latch = 1'h0;
		end
		if (main_set) begin
			s_d.main_latch = 1'h1;
		end
		if (sec_ack) begin
			s_d.sec_latch = 1'h0;
		end
		if (sec_set) begin
			s_d.sec_latch = 1'h1;
		end
		if (csr_wr) begin
			s_d.main_en = bus_i.wdata[EPI_MAIN_EN_BIT];
			s_d.sec_en = bus_i.wdata[EPI_SEC_EN_BIT];
		end
		if (stop_wait_i) begin
			s_d.main_en = 1'h1;
		end
		// data stands one cycle, zero otherwise
		s_d.rdata = EPI_ZERO_BYTE;
		if (csr_rd) begin
			s_d.rdata = status;
		end
	end

	// ==========================================
	// State register
	// reset values
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			// Idle-high stages, so no false edge after reset
			s_q.irq_sync <= {2{EPI_PIN_IDLE_HI}};
			s_q.irq_seen <= {2{EPI_PIN_IDLE_HI}};
			s_q.high_sync <= {2{EPI_PIN_IDLE_HI}};
			s_q.high_seen <= EPI_PIN_IDLE_HI;
			s_q.main_en <= EPI_MAIN_EN_RST;
			s_q.sec_en <= EPI_SEC_EN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs
	assign rdata_o = s_q.rdata;
	assign main_live = main_flag & s_q.main_en;
	assign sec_live = s_q.sec_latch & s_q.sec_en;
	// held while any live; CPU mask
	assign irq_req_o = ~cpu_imask_i & (main_live | sec_live);
	assign irq_vec_o = EPI_VEC_HI_ADDR;
	assign branch_pin_level_o = irq_now;
endmodule

// ===== hdl/epi_pkg.sv
// Purpose: Shared constants and types for the external pin interrupt logic
// Assumes: One 25 MHz processor bus clock
// Notes: Register bit layout chosen locally
package epi_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] EPI_CSR_ADDR = 8'h0A;
	localparam logic [15:0] EPI_VEC_HI_ADDR = 16'h0FFA;
	localparam logic [15:0] EPI_VEC_LO_ADDR = 16'h0FFB;
	// ==========================================
	// Field positions
	localparam int EPI_SEC_ACK_BIT = 0;
	localparam int EPI_MAIN_ACK_BIT = 1;
	localparam int EPI_SEC_FLAG_BIT = 2;
	localparam int EPI_MAIN_FLAG_BIT = 3;
	localparam int EPI_SEC_EN_BIT = 4;
	localparam int EPI_MAIN_EN_BIT = 5;
	// ==========================================
	// Reset values
	localparam logic EPI_MAIN_EN_RST = 1'h1;
	localparam logic EPI_SEC_EN_RST = 1'h0;
	// Synchroniser stages of active-low pins start at their idle level
	localparam logic EPI_PIN_IDLE_HI = 1'h1;
	localparam logic [7:0] EPI_ZERO_BYTE = 8'h00;
	localparam logic [3:0] EPI_ZERO_NIB = 4'h0;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} epi_bus_req_t;

	typedef struct packed {
		logic irq_pin_b;
		logic [3:0] low_port_pin_group;
		logic high_port_pin;
	} epi_pins_t;

	typedef struct packed {
		logic [1:0] irq_sync;
		logic [1:0] irq_seen;
		logic [3:0] low_sync0;
		logic [3:0] low_sync1;
		logic [3:0] low_seen;
		logic [1:0] high_sync;
		logic high_seen;
		logic main_latch;
		logic sec_latch;
		logic main_en;
		logic sec_en;
		logic [7:0] rdata;
	} epi_state_t;
endpackage

// ===== dv/epi_ctrl_properties.sv
// Purpose: Port checks for epi_ctrl
// Assumes: Level checks follow the bound option
// Notes: Flags are seen through CSR reads
`timescale 1ns/1ns
module epi_ctrl_properties import epi_pkg::*; #(
	parameter bit LEVEL_SENS_OPT = 1'h0
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire epi_bus_req_t bus_i,
	input wire logic [7:0] rdata_o,
	input wire epi_pins_t pins_i,
	input wire logic cpu_imask_i,
	input wire logic vec_fetch_i,
	input wire logic stop_wait_i,
	input wire logic irq_req_o,
	input wire logic [15:0] irq_vec_o,
	input wire logic branch_pin_level_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// ==========================================
	// Checks
	sequence rd_csr; bus_i.rd && bus_i.addr == EPI_CSR_ADDR; endsequence
	sequence ack(int b); bus_i.wr && bus_i.addr == EPI_CSR_ADDR && bus_i.wdata[b]; endsequence
	a_mask_gates: assert property (cpu_imask_i |-> !irq_req_o) else $error("mask");
	a_idle_zero: assert property (!bus_i.rd |=> rdata_o == 8'h00) else $error("idle data");
	a_unused_zero: assert property (rd_csr |=> (rdata_o & 8'hC3) == 8'h00) else $error("unused");
	a_stop_enable: assert property (stop_wait_i ##1 rd_csr |=> rdata_o[5]) else $error("stop");
	a_branch_raw: assert property ($stable(pins_i.irq_pin_b) [*4] |-> branch_pin_level_o == pins_i.irq_pin_b)
		else $error("branch level");
	// Pins quiet so no set can beat the clear
	a_level_flag: assert property (rd_csr ##0 (LEVEL_SENS_OPT == 1'h1) ##0 !branch_pin_level_o |=> rdata_o[3])
		else $error("level flag");
	a_main_ack: assert property ($stable(pins_i) [*5] ##0 ack(1) ##0 (LEVEL_SENS_OPT == 1'h0) ##[2:3] rd_csr
		|=> !rdata_o[3])
		else $error("main ack");
	a_sec_ack: assert property ($stable(pins_i.high_port_pin) [*5] ##0 ack(0) ##[2:3] rd_csr |=> !rdata_o[2])
		else $error("sec ack");
	a_live_req: assert property (rd_csr ##0 !vec_fetch_i ##0 (LEVEL_SENS_OPT == 1'h0)
		##1 !cpu_imask_i && (rdata_o[5:4] & rdata_o[3:2]) != 2'h0
		|-> irq_req_o) else $error("request");
endmodule
bind epi_ctrl epi_ctrl_properties #(.LEVEL_SENS_OPT(LEVEL_SENS_OPT)) chk (.*);

// ===== dv/epi_pin_model.sv
// Purpose: External pin sources for epi_ctrl
// Assumes: Pins only move on command
// Notes: Slow path lags one cycle like a sluggish source
`timescale 1ns/1ns
module epi_pin_model import epi_pkg::*; (
	input wire logic mclk_i,
	input wire epi_pins_t want_i,
	input wire logic slow_i,
	output epi_pins_t pins_o
);
	epi_pins_t held = 6'h21;
	always_ff @(posedge mclk_i) held <= want_i;
	assign pins_o = slow_i ? held : want_i;
endmodule

// ===== dv/external_pin_interrupt_logic_tb.sv
// Purpose: Self-checking bench for epi_ctrl
// Assumes: dut edge-only; dut_lvl has group and level options
// Notes: Seeded pin lag and stray writes
`timescale 1ns/1ns
module external_pin_interrupt_logic_tb import epi_pkg::*; ;
	localparam logic [7:0] A = EPI_CSR_ADDR;
	logic clk = 0, rst_b = 0, imask = 0, vf = 0, sw = 0, slow = 0, irq, bpl;
	logic [7:0] rdata;
	logic [15:0] vec;
	logic [7:0] rdata_l, rdl;
	logic irq_l;
	epi_bus_req_t bus = '0;
	epi_pins_t want = 6'h21, pins;
	int bad_count = 0, comparisons = 0, seed = 4;
	epi_pin_model pm (.mclk_i(clk), .want_i(want), .slow_i(slow), .pins_o(pins));
	epi_ctrl dut (.mclk_i(clk), .rst_b_i(rst_b), .bus_i(bus), .rdata_o(rdata), .pins_i(pins), .cpu_imask_i(imask),
		.vec_fetch_i(vf), .stop_wait_i(sw), .irq_req_o(irq), .irq_vec_o(vec), .branch_pin_level_o(bpl));
	epi_ctrl #(.LOW_GROUP_OPT(1'h1), .LEVEL_SENS_OPT(1'h1)) dut_lvl (.mclk_i(clk), .rst_b_i(rst_b), .bus_i(bus),
		.rdata_o(rdata_l), .pins_i(pins), .cpu_imask_i(imask), .vec_fetch_i(vf), .stop_wait_i(sw),
		.irq_req_o(irq_l), .irq_vec_o(), .branch_pin_level_o());
	initial forever #20 clk = ~clk;
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
	function automatic logic [7:0] ex(logic me, logic se, logic mf, logic sf);
		return {2'h0, me, se, mf, sf, 2'h0};
	endfunction
	task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic op(logic w, logic [7:0] a, logic [7:0] d);
		bus <= '{a, d, w, !w};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		rdl = rdata_l;
		if (!w) cmp("csr", d, rdata);
		@(posedge clk);
	endtask
	task automatic req(logic e);
		@(negedge clk);
		cmp("irq", 8'(e), 8'(irq));
		cmp("vec hi", EPI_VEC_HI_ADDR[15:8], vec[15:8]);
		cmp("vec lo", EPI_VEC_HI_ADDR[7:0], vec[7:0]);
		cmp("branch", 8'(want.irq_pin_b), 8'(bpl));
		@(posedge clk);
	endtask
	task automatic tally_and_finish;
		$display("Mismatches %0d of %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1;
		slow <= 1'($random(seed));
		op(0, A, ex(1, 0, 0, 0));
		op(1, 8'h0B, 8'($random(seed)));
		op(0, 8'h0B, 8'h00);
		want <= 6'h01;
		repeat (7) @(posedge clk);
		op(0, A, ex(1, 0, 1, 0));
		req(1);
		imask <= 1;
		op(1, A, 8'h2C);
		req(0);
		op(0, A, ex(1, 0, 1, 0));
		want <= 6'h21;
		slow <= 1'($random(seed));
		repeat (6) @(posedge clk);
		op(1, A, 8'h32);
		op(0, A, ex(1, 1, 0, 0));
		want <= 6'h00;
		repeat (7) @(posedge clk);
		vf <= 1;
		@(posedge clk);
		vf <= 0;
		op(0, A, ex(1, 1, 1, 1));
		imask <= 0;
		req(1);
		op(1, A, 8'h11);
		sw <= 1;
		@(posedge clk);
		sw <= 0;
		op(0, A, ex(1, 1, 1, 0));
		op(1, A, 8'h20);
		vf <= 1;
		@(posedge clk);
		vf <= 0;
		op(0, A, ex(1, 0, 0, 0));
		want <= 6'h21;
		repeat (6) @(posedge clk);
		op(1, A, 8'h22);
		op(0, A, ex(1, 0, 0, 0));
		cmp("lvl csr", ex(1, 0, 0, 0), rdl);
		want <= 6'h23;
		@(posedge clk);
		want <= 6'h21;
		repeat (6) @(posedge clk);
		op(0, A, ex(1, 0, 0, 0));
		cmp("lvl csr", ex(1, 0, 1, 0), rdl);
		want <= 6'h23;
		repeat (7) @(posedge clk);
		op(1, A, 8'h22);
		op(0, A, ex(1, 0, 0, 0));
		cmp("lvl csr", ex(1, 0, 1, 0), rdl);
		@(negedge clk);
		cmp("lvl irq", 8'h01, 8'(irq_l));
		@(posedge clk);
		want <= 6'h21;
		repeat (6) @(posedge clk);
		op(1, A, 8'h22);
		op(0, A, ex(1, 0, 0, 0));
		cmp("lvl csr", ex(1, 0, 0, 0), rdl);
		tally_and_finish;
	end
endmodule
